// *** rtl/ctc_timer.sv ***
// counter/timer, bit rate generator and clock pin logic
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module ctc_timer
   import ctc_pkg::*;
#(
   parameter int XTAL_HZ = 3686400,   // crystal rate behind the tick
   parameter int RATE_SEL_W = 4       // width of rate selector
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // register port
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   // crystal tick and pins from outside
   input wire logic crystal_clock_in_i,
   input wire logic [3:0] ext_clock_inputs_i,
   input wire logic chan_a_tx_clock_i,
   input wire logic chan_b_tx_clock_i,
   // channel clock selection request
   input wire logic [RATE_SEL_W-1:0] rate_sel_i,
   // outputs
   output logic output_pin_three_o,
   output logic timer_clock_o,
   output logic bit_rate_clock_o,
   output logic [3:0] ext_clock_o,
   output logic irq_o
);
   // elaboration checks: the rate table is built for a 4-bit code
   initial begin
      if (RATE_SEL_W != 4) $error("rate selector must be 4 bits");
      if (XTAL_HZ <= 0) $error("crystal rate must be positive");
   end

   // bus carrier
   ctc_bus_t bus;
   assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

   // pin synchronisers: s1 only feeds s2
   // pins are asynchronous to clk_i, so nothing but the second
   // stage may look at the first, or a metastable value leaks in
   logic [7:0] sync1;
   logic [7:0] sync2;
   logic [7:0] sync3; // previous for edge detect
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         sync1 <= 8'h00;
         sync2 <= 8'h00;
         sync3 <= 8'h00;
      end else begin
         sync1 <= {1'b0, crystal_clock_in_i, chan_b_tx_clock_i,
                   chan_a_tx_clock_i, ext_clock_inputs_i};
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end
   // rising edges of the synchronised pins
   wire [7:0] rise = sync2 & ~sync3;
   wire pin_two_rise = rise[0];
   wire txa_rise = rise[4];
   wire txb_rise = rise[5];
   wire xtal_rise = rise[6];

   // registers
   logic [7:0] aux_control_reg;
   logic [7:0] preload_high_byte;
   logic [7:0] preload_low_byte;
   logic [7:0] int_mask_reg;
   logic [7:0] int_status_reg;

   // decodes
   wire wr_aux = bus.wr && bus.addr == OFS_AUX_CONTROL;
   wire wr_hi = bus.wr && bus.addr == OFS_PRELOAD_HIGH;
   wire wr_lo = bus.wr && bus.addr == OFS_PRELOAD_LOW;
   wire wr_mask = bus.wr && bus.addr == OFS_INT_MASK;
   wire wr_clr = bus.wr && bus.addr == OFS_INT_CLEAR;
   wire cmd_start = (bus.wr || bus.rd) && bus.addr == OFS_CMD_START;
   wire cmd_stop = (bus.wr || bus.rd) && bus.addr == OFS_CMD_STOP;

   // mode and source
   wire timer_mode = aux_control_reg[ACR_MODE_BIT];
   ctc_src_t src;
   assign src = ctc_src_t'(aux_control_reg[ACR_SRC_HI:ACR_SRC_LO]);
   wire [15:0] preload = {preload_high_byte, preload_low_byte};

   // divide-by-16 prescalers for crystal and pin two
   logic [3:0] xdiv;
   logic [3:0] pdiv;
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         xdiv <= 4'h0;
         pdiv <= 4'h0;
      end else begin
         if (xtal_rise) xdiv <= xdiv + 4'h1;
         if (pin_two_rise) pdiv <= pdiv + 4'h1;
      end
   end
   wire xtal_d16 = xtal_rise && xdiv == 4'(DIV16 - 1);
   wire pin_d16 = pin_two_rise && pdiv == 4'(DIV16 - 1);

   // source tick select
   logic tick;
   always_comb begin
      case (src)
         SRC_CNT_PIN: tick = pin_two_rise;
         SRC_CNT_TXA: tick = txa_rise;
         SRC_CNT_TXB: tick = txb_rise;
         SRC_CNT_XD16: tick = xtal_d16;
         SRC_TMR_PIN: tick = pin_two_rise;
         SRC_TMR_PD16: tick = pin_d16;
         SRC_TMR_X: tick = xtal_rise;
         SRC_TMR_XD16: tick = xtal_d16;
         default: tick = 1'b0;
      endcase
   end

   // counter core
   logic [15:0] count;
   logic running;
   logic square;
   logic terminal; // counter reached zero since start, with no counter-mode stop since
   wire half_end = timer_mode && running && tick && count <= 16'h0001;
   wire cnt_zero = !timer_mode && running && tick && count == 16'h0001;
   wire ready_evt = (half_end && square) || cnt_zero;
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         count <= 16'h0000;
         running <= 1'b0;
         square <= 1'b1;
         terminal <= 1'b0;
      end else if (cmd_start) begin
         count <= preload;
         running <= 1'b1;
         square <= 1'b1;
         terminal <= 1'b0;
      end else if (cmd_stop && !timer_mode) begin
         running <= 1'b0;
         terminal <= 1'b0;
      end else if (running && tick) begin
         if (timer_mode) begin
            if (count <= 16'h0001) begin
               count <= preload;
               square <= ~square;
            end else begin
               count <= count - 16'h0001;
            end
         end else begin
            count <= count - 16'h0001;
            if (count == 16'h0001) terminal <= 1'b1;
         end
      end
   end

   // interrupt status: set wins over clear
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         int_status_reg <= 8'h00;
      end else begin
         int_status_reg[ST_READY_BIT] <= ready_evt ||
            (int_status_reg[ST_READY_BIT] && !cmd_stop &&
             !(wr_clr && bus.wdata[ST_READY_BIT]));
      end
   end

   // writable registers
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         aux_control_reg <= AUX_RESET;
         preload_high_byte <= PRELOAD_RESET;
         preload_low_byte <= PRELOAD_RESET;
         int_mask_reg <= MASK_RESET;
      end else begin
         if (wr_aux) aux_control_reg <= bus.wdata;
         if (wr_hi) preload_high_byte <= bus.wdata;
         if (wr_lo) preload_low_byte <= bus.wdata;
         if (wr_mask) int_mask_reg <= bus.wdata;
      end
   end

   // bit rate generator: phase accumulator, 16x rate output
   // the accumulator adds one step per crystal rise, so the output
   // follows the crystal; other crystal rates scale every rate alike
   // steps are rounded, so odd rates carry a small phase jitter
   logic [BRG_ACC_W-1:0] brg_acc;
   logic [BRG_ACC_W-1:0] brg_step;
   always_comb begin
      // step = 16*rate/xtal*2^24, nearest value for a 3.6864 MHz xtal
      case ({aux_control_reg[ACR_RATE_SET_BIT], rate_sel_i})
         5'h00: brg_step = 24'h000e39;  // 50
         5'h01: brg_step = 24'h001f4a;  // 110
         5'h02: brg_step = 24'h002642;  // 134.5
         5'h03: brg_step = 24'h0038e4;  // 200
         5'h04: brg_step = 24'h005555;  // 300
         5'h05: brg_step = 24'h00aaab;  // 600
         5'h06: brg_step = 24'h015555;  // 1200
         5'h07: brg_step = 24'h012aab;  // 1050
         5'h08: brg_step = 24'h02aaab;  // 2400
         5'h09: brg_step = 24'h055555;  // 4800
         5'h0a: brg_step = 24'h080000;  // 7200
         5'h0b: brg_step = 24'h0aaaab;  // 9600
         5'h0c: brg_step = 24'h2aaaab;  // 38.4k
         5'h10: brg_step = 24'h001555;  // 75
         5'h11: brg_step = 24'h001f4a;  // 110
         5'h12: brg_step = 24'h002642;  // 134.5
         5'h13: brg_step = 24'h002aab;  // 150
         5'h14: brg_step = 24'h005555;  // 300
         5'h15: brg_step = 24'h00aaab;  // 600
         5'h16: brg_step = 24'h015555;  // 1200
         5'h17: brg_step = 24'h0238e4;  // 2000
         5'h18: brg_step = 24'h02aaab;  // 2400
         5'h19: brg_step = 24'h055555;  // 4800
         5'h1a: brg_step = 24'h020000;  // 1800
         5'h1b: brg_step = 24'h0aaaab;  // 9600
         5'h1c: brg_step = 24'h155555;  // 19.2k
         default: brg_step = 24'h000000;
      endcase
   end
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         brg_acc <= '0;
      end else if (xtal_rise) begin
         brg_acc <= brg_acc + brg_step;
      end
   end

   // read mux
   logic [7:0] next_rdata;
   always_comb begin
      case (bus.addr)
         OFS_AUX_CONTROL: next_rdata = aux_control_reg;
         OFS_PRELOAD_HIGH: next_rdata = preload_high_byte;
         OFS_PRELOAD_LOW: next_rdata = preload_low_byte;
         OFS_INT_STATUS: next_rdata = int_status_reg;
         OFS_INT_MASK: next_rdata = int_mask_reg;
         OFS_COUNT_HIGH: next_rdata = count[15:8];
         OFS_COUNT_LOW: next_rdata = count[7:0];
         default: next_rdata = 8'h00;
      endcase
   end

   // registered outputs
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         rdata_o <= 8'h00;
         output_pin_three_o <= 1'b1;
         timer_clock_o <= 1'b1;
         bit_rate_clock_o <= 1'b0;
         ext_clock_o <= 4'h0;
         irq_o <= 1'b0;
      end else begin
         rdata_o <= bus.rd ? next_rdata : 8'h00;
         output_pin_three_o <= timer_mode ? square
                               : !terminal;
         timer_clock_o <= square;
         bit_rate_clock_o <= brg_acc[BRG_ACC_W-1];
         ext_clock_o <= sync2[3:0];
         irq_o <= |(int_status_reg & int_mask_reg);
      end
   end

   // assertions
   // each one but a_counter_stop_pin and a_terminal_pin_low looks one edge past the cause, since every state bit
   // and every output here is a flip-flop on clk_i
   a_start_loads: assert property (@(posedge clk_i) disable iff (reset_i)
      cmd_start |=> count == $past(preload) && running)
      else $error("start did not load preload");
   a_stop_clears_ready: assert property (@(posedge clk_i)
      disable iff (reset_i)
      cmd_stop && !ready_evt |=> !int_status_reg[ST_READY_BIT])
      else $error("stop did not clear ready");
   a_set_wins: assert property (@(posedge clk_i) disable iff (reset_i)
      ready_evt |=> int_status_reg[ST_READY_BIT])
      else $error("ready event lost");
   a_counter_wrap: assert property (@(posedge clk_i)
      disable iff (reset_i)
      !timer_mode && running && tick && count == 16'h0000 && !cmd_start
      && !cmd_stop |=> count == 16'hffff)
      else $error("counter did not wrap");
   a_timer_toggle: assert property (@(posedge clk_i) disable iff (reset_i)
      half_end && !cmd_start |=> square != $past(square))
      else $error("square did not toggle");
   a_counter_stop_pin: assert property (@(posedge clk_i)
      disable iff (reset_i)
      cmd_stop && !cmd_start && !timer_mode |=> ##1 output_pin_three_o)
      else $error("pin three not high after stop");
   a_timer_keeps_run: assert property (@(posedge clk_i)
      disable iff (reset_i)
      cmd_stop && timer_mode && running |=> running)
      else $error("timer stopped by stop");
   a_irq_follows: assert property (@(posedge clk_i) disable iff (reset_i)
      |(int_status_reg & int_mask_reg) |=> irq_o)
      else $error("interrupt not raised");

   // counter-mode step that brings the count to zero
   sequence s_cnt_last;
      !timer_mode && running && tick && count == 16'h0001
      && !cmd_start && !cmd_stop;
   endsequence
   // the cycle after: still counter mode, no start or stop
   sequence s_cnt_after;
      !timer_mode && !cmd_start && !cmd_stop;
   endsequence
   // ready flag and terminal mark follow the zero step
   a_zero_sets_ready: assert property (@(posedge clk_i)
      disable iff (reset_i)
      s_cnt_last |=> int_status_reg[ST_READY_BIT] && terminal)
      else $error("zero count did not set ready");
   // pin three drops once the terminal mark is seen
   a_terminal_pin_low: assert property (@(posedge clk_i)
      disable iff (reset_i)
      s_cnt_last ##1 s_cnt_after |=> !output_pin_three_o)
      else $error("pin three not low at terminal");
   // a stop in counter mode halts the count
   a_stop_halts: assert property (@(posedge clk_i)
      disable iff (reset_i)
      cmd_stop && !cmd_start && !timer_mode |=> !running)
      else $error("counter kept running after stop");
   // counter mode: preload writes leave the count alone
   a_count_holds: assert property (@(posedge clk_i)
      disable iff (reset_i)
      !timer_mode && !cmd_start && !(running && tick)
      |=> count == $past(count))
      else $error("count moved without a tick");
   // each half-cycle end of the timer picks up the preload
   a_timer_reload: assert property (@(posedge clk_i)
      disable iff (reset_i)
      half_end && !cmd_start |=> count == $past(preload))
      else $error("timer did not reload at half cycle");
   // a start opens a fresh cycle in its high half
   a_start_square: assert property (@(posedge clk_i)
      disable iff (reset_i)
      cmd_start |=> square)
      else $error("start did not restart the square");
   // ready only rises on its event
   a_ready_needs_event: assert property (@(posedge clk_i)
      disable iff (reset_i)
      !ready_evt && !int_status_reg[ST_READY_BIT]
      |=> !int_status_reg[ST_READY_BIT])
      else $error("ready set without an event");
   // no enabled status bit, no interrupt
   a_irq_quiet: assert property (@(posedge clk_i)
      disable iff (reset_i)
      !(|(int_status_reg & int_mask_reg)) |=> !irq_o)
      else $error("interrupt raised with nothing enabled");
   // timer mode puts the square on pin three
   a_timer_pin: assert property (@(posedge clk_i)
      disable iff (reset_i)
      timer_mode |=> output_pin_three_o == $past(square))
      else $error("pin three does not carry the square");
   // clock pins reach the channel side one flop after the sync
   a_ext_pins: assert property (@(posedge clk_i)
      disable iff (reset_i)
      1'b1 |=> ext_clock_o == $past(sync2[3:0]))
      else $error("clock pins not passed on");
endmodule

// *** rtl/ctc_pkg.sv ***
// package for the counter/timer and clocking block
package ctc_pkg;
   // register offsets on the plain register port
   localparam logic [3:0] OFS_AUX_CONTROL = 4'h0;
   localparam logic [3:0] OFS_PRELOAD_HIGH = 4'h1;
   localparam logic [3:0] OFS_PRELOAD_LOW = 4'h2;
   localparam logic [3:0] OFS_INT_STATUS = 4'h3;
   localparam logic [3:0] OFS_INT_MASK = 4'h4;
   localparam logic [3:0] OFS_INT_CLEAR = 4'h5;
   localparam logic [3:0] OFS_CMD_START = 4'h6;
   localparam logic [3:0] OFS_CMD_STOP = 4'h7;
   localparam logic [3:0] OFS_COUNT_HIGH = 4'h8;
   localparam logic [3:0] OFS_COUNT_LOW = 4'h9;
   // aux control fields
   localparam int ACR_RATE_SET_BIT = 7;
   localparam int ACR_MODE_BIT = 6;
   localparam int ACR_SRC_HI = 6;
   localparam int ACR_SRC_LO = 4;
   // status bit positions
   localparam int ST_READY_BIT = 3;
   // reset values
   localparam logic [7:0] AUX_RESET = 8'h00;
   localparam logic [7:0] PRELOAD_RESET = 8'h00;
   localparam logic [7:0] MASK_RESET = 8'h00;
   // prescale and generator constants
   localparam int DIV16 = 16;
   localparam int BRG_ACC_W = 24;
   // register bus carrier
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } ctc_bus_t;
   // count source selections
   typedef enum logic [2:0] {
      SRC_CNT_PIN, SRC_CNT_TXA, SRC_CNT_TXB, SRC_CNT_XD16,
      SRC_TMR_PIN, SRC_TMR_PD16, SRC_TMR_X, SRC_TMR_XD16
   } ctc_src_t;
endpackage

// *** tb/test_ctc_timer.sv ***
// self-checking bench for the counter/timer and clocking block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
   error_cnt++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module test_ctc_timer
   import ctc_pkg::*;
;
   // one register row: address, data written, value read back
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic [7:0] exp;
   } ctc_row_t;
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic [3:0] addr_i = 4'h0;
   logic [7:0] wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic crystal_clock_in_i = 1'b0;
   logic [3:0] ext_clock_inputs_i = 4'h0;
   logic [3:0] rate_sel_i = 4'hb;
   logic [1:0] tx_clk = 2'b00;
   int r;
   logic [7:0] rdata_o;
   logic output_pin_three_o, timer_clock_o, bit_rate_clock_o, irq_o;
   logic [3:0] ext_clock_o;
   int error_cnt = 0;
   int comparisons = 0;
   int n;
   logic [7:0] d;
   ctc_row_t rows [6];
   // device under test
   ctc_timer DUT (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .crystal_clock_in_i(crystal_clock_in_i),
      .ext_clock_inputs_i(ext_clock_inputs_i),
      .chan_a_tx_clock_i(tx_clk[0]), .chan_b_tx_clock_i(tx_clk[1]),
      .rate_sel_i(rate_sel_i), .output_pin_three_o(output_pin_three_o),
      .timer_clock_o(timer_clock_o), .bit_rate_clock_o(bit_rate_clock_o),
      .ext_clock_o(ext_clock_o), .irq_o(irq_o));
   // 50 ns clock
   initial begin
      forever #25 clk_i = ~clk_i;
   end
   // free running crystal tick, one rise every two cycles
   always @(posedge clk_i) begin
      crystal_clock_in_i <= ~crystal_clock_in_i;
   end
   // one-cycle write strobe
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   // one-cycle read strobe, data taken in the following cycle
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 v = rdata_o;
   endtask
   // read and compare one register
   task automatic rchk(input logic [3:0] a, input logic [7:0] e);
      logic [7:0] v;
      rd(a, v);
      `CHK("register", e, v)
   endtask
   // current count, high byte then low byte
   task automatic cchk(input logic [15:0] e);
      rchk(OFS_COUNT_HIGH, e[15:8]);
      rchk(OFS_COUNT_LOW, e[7:0]);
   endtask
   // one clean pulse: 0 pin two, 1 tx clock A, 2 tx clock B
   task automatic pulse(input int k = 0);
      @(posedge clk_i);
      if (k == 0) ext_clock_inputs_i[0] <= 1'b1;
      else if (k == 1) tx_clk[0] <= 1'b1;
      else tx_clk[1] <= 1'b1;
      repeat (4) @(posedge clk_i);
      ext_clock_inputs_i[0] <= 1'b0;
      tx_clk <= 2'b00;
      repeat (5) @(posedge clk_i);
   endtask
   // rising edges of the generator clock over a window
   task automatic rises(input int cyc, output int cnt);
      logic p;
      cnt = 0;
      repeat (4) @(posedge clk_i);
      #1 p = bit_rate_clock_o;
      repeat (cyc) begin
         @(posedge clk_i);
         #1;
         if (!p && bit_rate_clock_o) cnt++;
         p = bit_rate_clock_o;
      end
   endtask
   // cycles between two rises of the square, bounded waits
   task automatic meas(output int cyc);
      logic p;
      int i;
      cyc = 0;
      p = timer_clock_o;
      for (i = 0; i < 200; i++) begin
         @(posedge clk_i);
         #1;
         if (!p && timer_clock_o) break;
         p = timer_clock_o;
      end
      p = timer_clock_o;
      for (i = 0; i < 200; i++) begin
         @(posedge clk_i);
         #1;
         cyc++;
         if (!p && timer_clock_o) break;
         p = timer_clock_o;
      end
   endtask
   // verdict and end of run
   task automatic complete_run();
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // watchdog against a hang
   initial begin
      repeat (20000) @(posedge clk_i);
      error_cnt++;
      complete_run();
   end
   // main sequence
   initial begin
      rows[0] = '{OFS_AUX_CONTROL, 8'h80, 8'h80};
      rows[1] = '{OFS_PRELOAD_HIGH, 8'h12, 8'h12};
      rows[2] = '{OFS_PRELOAD_LOW, 8'h34, 8'h34};
      rows[3] = '{OFS_INT_MASK, 8'h08, 8'h08};
      rows[4] = '{OFS_INT_STATUS, 8'hff, 8'h00};
      rows[5] = '{4'hf, 8'h5a, 8'h00};
      repeat (20) @(posedge clk_i);
      reset_i <= 1'b0;
      #1;
      `CHK("pin three", 1'b1, output_pin_three_o)
      `CHK("irq", 1'b0, irq_o)
      rchk(OFS_AUX_CONTROL, AUX_RESET);
      rchk(OFS_PRELOAD_LOW, PRELOAD_RESET);
      foreach (rows[i]) begin
         wr(rows[i].addr, rows[i].wdata);
         rchk(rows[i].addr, rows[i].exp);
      end
      // counter mode counting pulses on pin two
      wr(OFS_AUX_CONTROL, 8'h00);
      wr(OFS_INT_MASK, 8'h00);
      wr(OFS_PRELOAD_HIGH, 8'h00);
      wr(OFS_PRELOAD_LOW, 8'h03);
      wr(OFS_CMD_START, 8'h00);
      cchk(16'h0003);
      pulse();
      pulse();
      cchk(16'h0001);
      rchk(OFS_INT_STATUS, 8'h00);
      `CHK("pin three", 1'b1, output_pin_three_o)
      pulse();
      cchk(16'h0000);
      rchk(OFS_INT_STATUS, 8'h08);
      `CHK("pin three", 1'b0, output_pin_three_o)
      `CHK("irq masked", 1'b0, irq_o)
      wr(OFS_INT_MASK, 8'h08);
      repeat (2) @(posedge clk_i);
      #1;
      `CHK("irq", 1'b1, irq_o)
      wr(OFS_INT_CLEAR, 8'h08);
      rchk(OFS_INT_STATUS, 8'h00);
      `CHK("irq cleared", 1'b0, irq_o)
      pulse();
      cchk(16'hffff);
      wr(OFS_PRELOAD_LOW, 8'h05);
      cchk(16'hffff);
      wr(OFS_CMD_START, 8'h00);
      cchk(16'h0005);
      pulse();
      wr(OFS_CMD_STOP, 8'h00);
      rchk(OFS_INT_STATUS, 8'h00);
      `CHK("pin three", 1'b1, output_pin_three_o)
      pulse();
      cchk(16'h0004);
      wr(OFS_CMD_START, 8'h00);
      cchk(16'h0005);
      // external clock pins passed on
      @(posedge clk_i);
      ext_clock_inputs_i[3:1] <= 3'b101;
      repeat (4) @(posedge clk_i);
      #1;
      `CHK("ext clock", 3'b101, ext_clock_o[3:1])
      // timer mode from the crystal tick
      wr(OFS_AUX_CONTROL, 8'h60);
      wr(OFS_PRELOAD_LOW, 8'h03);
      wr(OFS_CMD_START, 8'h00);
      meas(n);
      `CHK("period", 12, n)
      `CHK("pin three", 1'b1, output_pin_three_o)
      wr(OFS_PRELOAD_LOW, 8'h05);
      meas(n);
      meas(n);
      `CHK("period", 20, n)
      rchk(OFS_INT_STATUS, 8'h08);
      wr(OFS_CMD_STOP, 8'h00);
      rchk(OFS_INT_STATUS, 8'h00);
      meas(n);
      `CHK("period", 20, n)
      // timer from crystal over sixteen, preload one
      wr(OFS_PRELOAD_LOW, 8'h01);
      wr(OFS_AUX_CONTROL, 8'h70);
      wr(OFS_CMD_START, 8'h00);
      meas(n);
      `CHK("period", 64, n)
      // counter mode on the channel transmit clocks
      wr(OFS_AUX_CONTROL, 8'h10);
      wr(OFS_PRELOAD_LOW, 8'h02);
      wr(OFS_CMD_START, 8'h00);
      pulse(1);
      pulse(2);
      pulse(0);
      cchk(16'h0001);
      wr(OFS_AUX_CONTROL, 8'h20);
      pulse(2);
      cchk(16'h0000);
      wr(OFS_CMD_STOP, 8'h00);
      // generator code a: 7200 in set zero, 1800 in set one
      @(posedge clk_i);
      rate_sel_i <= 4'ha;
      rises(640, r);
      `CHK("rate set 0", 10, r)
      wr(OFS_AUX_CONTROL, 8'h80);
      rises(1024, r);
      `CHK("rate set 1", 4, r)
      // reset in mid-run
      @(posedge clk_i);
      reset_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      reset_i <= 1'b0;
      #1;
      `CHK("pin three", 1'b1, output_pin_three_o)
      `CHK("square", 1'b1, timer_clock_o)
      `CHK("irq", 1'b0, irq_o)
      rchk(OFS_AUX_CONTROL, AUX_RESET);
      complete_run();
   end
endmodule
